// [logic/dpram_regs.vh]
// dpram_regs.vh: shared constants of the dual-port memory block
// assumes: included by bare name from the design files
`ifndef DPRAM_REGS_VH
`define DPRAM_REGS_VH
`define DPRAM_MODULE_BITS 9216
`define DPRAM_NATIVE_WIDTH 18
`define DPRAM_NATIVE_DEPTH 512
`define DPRAM_NATIVE_ABITS 9
`define DPRAM_HALF_WIDTH 9
`define DPRAM_TDP_ABITS 10
`define DPRAM_MODE_SINGLE 2'h0
`define DPRAM_MODE_VERT 2'h1
`define DPRAM_MODE_HORIZ 2'h2
`define DPRAM_MODE_TRUE 2'h3
`endif

// [logic/dpram_core.v]
// dpram_core.v: one 512 x 18 storage module, separate write and read clocks
// assumes: clocks come already polarity-selected from the parent
`timescale 1ns/100ps
`default_nettype none
`include "dpram_regs.vh"
module dpram_core #(
    parameter DEPTH = `DPRAM_NATIVE_DEPTH,
    parameter ABITS = `DPRAM_NATIVE_ABITS,
    parameter HALF = `DPRAM_HALF_WIDTH,
    parameter PIPE = 0
) (
    input wire writeClock, // write side clock
    input wire writeSelect, // write chip select
    input wire [1:0] writeEnable, // per-half write enables
    input wire [ABITS-1:0] writeAddress, // write word address
    input wire [2*HALF-1:0] writeData, // write word
    input wire readClock, // read side clock
    input wire readSelect, // read chip select
    input wire [ABITS-1:0] readAddress, // read word address
    output wire [2*HALF-1:0] readData // read word
);
    reg [HALF-1:0] memLow [0:DEPTH-1];
    reg [HALF-1:0] memHigh [0:DEPTH-1];
    reg [2*HALF-1:0] readStage;
    reg [2*HALF-1:0] readPipe;
    // ****************************************
    // write side
    // ****************************************
    always @(posedge writeClock)
    begin
        if (writeSelect && writeEnable[0])
            memLow[writeAddress] <= writeData[HALF-1:0];
        if (writeSelect && writeEnable[1])
            memHigh[writeAddress] <= writeData[2*HALF-1:HALF];
    end
    // ****************************************
    // read side
    // ****************************************
    // no collision guard: same-address read during write is undefined
    always @(posedge readClock)
    begin
        if (readSelect)
            readStage <= {memHigh[readAddress], memLow[readAddress]};
        readPipe <= readStage;
    end
    assign readData = (PIPE != 0) ? readPipe : readStage;
endmodule // dpram_core
`default_nettype wire

// [logic/dpram_clock_sel.v]
// dpram_clock_sel.v: picks true or inverted form of a port clock
// assumes: invert choice is static configuration
`timescale 1ns/100ps
`default_nettype none
module dpram_clock_sel #(
    parameter INVERT = 0
) (
    input wire clockIn, // raw port clock
    output wire clockOut // clock used by the port
);
    assign clockOut = (INVERT != 0) ? ~clockIn : clockIn;
endmodule // dpram_clock_sel
`default_nettype wire

// [logic/dpram_block.v]
// dpram_block.v: pair of 9216-bit memory modules with configurable shape
// assumes: user fabric drives all ports; no reset, contents start unknown
// Notes on behaviour
// - each module 9216 bits, one write, one read
// - native 512 x 18, 9-bit addresses
// - write width follows DEPTH and MODE; RWIDTH only masks read data
// - write and read ports own clocks
// - each port clock may be inverted
// - two write enables, one per 9-bit half; writeEnable[0] only at 2048 deep, one enable per port in true mode
// - read data direct or pipelined
// - two modules join as 1024x18 or 512x36
// - depth and width set address decoding
// - true dual-port: two read/write ports; port B reads of module 0 rows use port A's row
// - each port 18-bit data, 10-bit address
// - both ports may read one address; port A reads of module 1 rows return module 0 data
`timescale 1ns/100ps
`default_nettype none
`include "dpram_regs.vh"
module dpram_block #(
    parameter MODE = `DPRAM_MODE_SINGLE, // shape of the pair
    parameter DEPTH = 512, // logical depth: 512, 1024 or 2048
    parameter WWIDTH = 18, // write / first port width, unused: write width follows DEPTH and MODE
    parameter RWIDTH = 18, // read width: masks readData only, second port data is not masked
    parameter WCLK_INV = 0, // invert write / first port clock
    parameter RCLK_INV = 0, // invert read / second port clock
    parameter PIPE = 0 // pipelined read data
) (
    input wire writeClock, // write clock, first port clock in true mode
    input wire write_port_select, // write chip select
    input wire [1:0] writeEnable, // per-half write enables
    input wire [10:0] write_address, // write address, low bits used
    input wire [35:0] write_data, // write data, low 18 bits used (low 9 at 2048 deep), all 36 in horizontal shape
    input wire readClock, // read clock, second port clock in true mode
    input wire readSelect, // read chip select
    input wire [10:0] read_address, // read address, low bits used
    output wire [35:0] readData, // read data, low RWIDTH valid
    input wire [17:0] first_port_write_data, // true mode port one data in
    input wire [9:0] first_port_address, // true mode port one address
    input wire first_port_write_enable, // true mode port one write
    input wire first_port_select, // true mode port one chip select
    output wire [17:0] first_port_read_data, // true mode port one data out
    input wire [17:0] second_port_write_data, // true mode port two data in
    input wire [9:0] second_port_address, // true mode port two address
    input wire second_port_write_enable, // true mode port two write
    input wire second_port_select, // true mode port two chip select
    output wire [17:0] second_port_read_data // true mode port two data out
);
    localparam HALF = `DPRAM_HALF_WIDTH;
    localparam NW = `DPRAM_NATIVE_WIDTH;
    localparam AB = `DPRAM_NATIVE_ABITS;
    localparam TDP = (MODE == `DPRAM_MODE_TRUE);
    // lanes per native word for narrow shapes: 2048 deep packs two 9-bit lanes
    localparam WSUB = (DEPTH == 2048) ? 2 : 1;
    localparam MSEL = (DEPTH >= 1024); // module picked by address above 9 bits
    // ****************************************
    // clocks
    // ****************************************
    wire wClk;
    wire rClk;
    dpram_clock_sel #(.INVERT(WCLK_INV)) wClkSel (
        .clockIn(writeClock),
        .clockOut(wClk)
    );
    dpram_clock_sel #(.INVERT(RCLK_INV)) rClkSel (
        .clockIn(readClock),
        .clockOut(rClk)
    );
    // ****************************************
    // per-port decoded requests
    // ****************************************
    // port A writes in simple modes, reads and writes in true mode
    reg [10:0] aAddr;
    reg [17:0] aData;
    reg [1:0] aEn;
    reg aSel;
    reg [10:0] bAddr;
    reg [17:0] bData;
    reg [1:0] bEn;
    reg bSel;
    always @*
    begin
        if (TDP)
        begin
            aAddr = {1'b0, first_port_address};
            bAddr = {1'b0, second_port_address};
            aData = first_port_write_data;
            bData = second_port_write_data;
            aEn = {2{first_port_write_enable}};
            bEn = {2{second_port_write_enable}};
            aSel = first_port_select;
            bSel = second_port_select;
        end
        else
        begin
            aAddr = write_address;
            bAddr = read_address;
            aData = write_data[17:0];
            bData = 18'h00000;
            aEn = writeEnable;
            bEn = 2'h0;
            aSel = write_port_select;
            bSel = readSelect;
        end
    end
    // ****************************************
    // address decoding by shape
    // ****************************************
    // module index, row, lane (9-bit half) for each port
    reg aMod;
    reg bMod;
    reg [AB-1:0] aRow;
    reg [AB-1:0] bRow;
    reg aLane;
    reg bLane;
    always @*
    begin
        aLane = 1'b0;
        bLane = 1'b0;
        if (WSUB == 2) // 2048 x 9
        begin
            aLane = aAddr[0];
            bLane = bAddr[0];
            aRow = aAddr[AB:1];
            bRow = bAddr[AB:1];
            aMod = aAddr[AB+1];
            bMod = bAddr[AB+1];
        end
        else if (MSEL) // 1024 x 18
        begin
            aRow = aAddr[AB-1:0];
            bRow = bAddr[AB-1:0];
            aMod = aAddr[AB];
            bMod = bAddr[AB];
        end
        else // 512 deep, one or two modules side by side
        begin
            aRow = aAddr[AB-1:0];
            bRow = bAddr[AB-1:0];
            aMod = 1'b0;
            bMod = 1'b0;
        end
    end
    // ****************************************
    // module requests
    // ****************************************
    // horizontal shape writes both modules at once, high 18 bits to module 1
    wire horiz = (MODE == `DPRAM_MODE_HORIZ);
    reg [17:0] aWord;
    reg [1:0] aHalf;
    always @*
    begin
        if (WSUB == 2) // narrow word goes to the addressed half
        begin
            aWord = {aData[HALF-1:0], aData[HALF-1:0]};
            aHalf = aLane ? {aEn[0], 1'b0} : {1'b0, aEn[0]};
        end
        else
        begin
            aWord = aData;
            aHalf = aEn;
        end
    end
    wire [1:0] m0WrEn = (aSel && (horiz || !aMod)) ? aHalf : 2'h0;
    wire [1:0] m1WrEn = (aSel && (horiz || aMod)) ? (horiz ? aEn : aHalf) : 2'h0;
    wire [17:0] m1WrData = horiz ? write_data[35:18] : aWord;
    // second write path of true mode lands on the write port of the module its address picks
    wire [1:0] bHalf = (WSUB == 2) ? (bLane ? {bEn[0], 1'b0} : {1'b0, bEn[0]}) : bEn;
    wire [17:0] bWord = (WSUB == 2) ? {bData[HALF-1:0], bData[HALF-1:0]} : bData;
    // ****************************************
    // storage: module 0 and module 1, each one write and one read port
    // ****************************************
    // each module gets one write port; in true mode port B writes are steered
    // to module 1 when addressed there, else share module 0 write port
    // limitation: in true mode both ports writing module 0 at once, A wins
    wire bWr0 = TDP && bSel && !bMod && (bHalf != 2'h0);
    wire bWr1 = TDP && bSel && bMod && (bHalf != 2'h0);
    wire aWr0 = (m0WrEn != 2'h0);
    wire aWr1 = (m1WrEn != 2'h0);
    wire [1:0] w0En = aWr0 ? m0WrEn : (bWr0 ? bHalf : 2'h0);
    wire [1:0] w1En = aWr1 ? m1WrEn : (bWr1 ? bHalf : 2'h0);
    wire [AB-1:0] w0Row = aWr0 ? aRow : bRow;
    wire [AB-1:0] w1Row = aWr1 ? aRow : bRow;
    wire [17:0] w0Data = aWr0 ? aWord : bWord;
    wire [17:0] w1Data = aWr1 ? m1WrData : bWord;
    // true mode: module 0 reads for port A, module 1 reads for port B, each
    // holding only its own rows; port B reads of module 0 rows use port A's row
    wire [17:0] q0;
    wire [17:0] q1;
    wire [AB-1:0] r0Row = TDP ? aRow : bRow;
    dpram_core #(.PIPE(PIPE)) modLow (
        .writeClock(wClk),
        .writeSelect(1'b1),
        .writeEnable(w0En),
        .writeAddress(w0Row),
        .writeData(w0Data),
        .readClock(TDP ? wClk : rClk),
        .readSelect(TDP ? aSel : bSel),
        .readAddress(r0Row),
        .readData(q0)
    );
    dpram_core #(.PIPE(PIPE)) modHigh (
        .writeClock(TDP ? rClk : wClk),
        .writeSelect(1'b1),
        .writeEnable(w1En),
        .writeAddress(w1Row),
        .writeData(w1Data),
        .readClock(rClk),
        .readSelect(bSel),
        .readAddress(bRow),
        .readData(q1)
    );
    // ****************************************
    // read data steering
    // ****************************************
    // module/lane of a read must be remembered through the read latency
    reg rModQ;
    reg rLaneQ;
    reg rModP;
    reg rLaneP;
    always @(posedge rClk)
    begin
        if (bSel)
        begin
            rModQ <= bMod;
            rLaneQ <= bLane;
        end
        rModP <= rModQ;
        rLaneP <= rLaneQ;
    end
    wire useMod = (PIPE != 0) ? rModP : rModQ;
    wire useLane = (PIPE != 0) ? rLaneP : rLaneQ;
    wire [17:0] bWordOut = useMod ? q1 : q0;
    wire [17:0] bNarrow = {9'h000, useLane ? bWordOut[17:9] : bWordOut[8:0]};
    wire [17:0] bOut = (WSUB == 2) ? bNarrow : bWordOut;
    wire [35:0] rdMask = (RWIDTH >= 36) ? {36{1'b1}} : ((36'h1 << RWIDTH) - 36'h1);
    assign readData = TDP ? 36'h000000000 :
        (horiz ? ({q1, q0} & rdMask) : ({18'h00000, bOut} & rdMask));
    // true mode: port A data always comes from module 0, right only when in range
    // limitation: port A reads of rows held in module 1 return module 0 data
    wire [17:0] aNarrow = {9'h000, aLane ? q0[17:9] : q0[8:0]};
    assign first_port_read_data = TDP ? ((WSUB == 2) ? aNarrow : q0) : 18'h00000;
    assign second_port_read_data = TDP ? bOut : 18'h00000;
endmodule // dpram_block
`default_nettype wire

// [test/dpram_block_assertions.sv]
// dpram_block_assertions.sv: port checker for the memory block
// assumes: 512x18 simple shape, unpipelined read, bench fills memory first
`timescale 1ns/100ps
`default_nettype none
module dpram_block_assertions (
    input wire logic writeClock, // write clock
    input wire logic write_port_select, // write select
    input wire logic [1:0] writeEnable, // half enables
    input wire logic [10:0] write_address, // write address
    input wire logic [35:0] write_data, // write word
    input wire logic readClock, // read clock
    input wire logic readSelect, // read select
    input wire logic [10:0] read_address, // read address
    input wire logic [35:0] readData, // read word
    input wire logic [17:0] first_port_read_data, // port one data
    input wire logic [17:0] second_port_read_data // port two data
);
    // ****
    // last full word written, followed through half writes
    // ****
    logic [9:0] ageCount = 10'h000;
    logic lastValid = 1'b0;
    logic [8:0] lastAddr;
    logic [17:0] lastData;
    always @(posedge readClock)
        if (ageCount != 10'h3FF)
            ageCount <= ageCount + 10'h001;
    always @(posedge writeClock)
        if (write_port_select && writeEnable == 2'h3)
        begin
            lastValid <= 1'b1;
            lastAddr <= write_address[8:0];
            lastData <= write_data[17:0];
        end
        else if (write_port_select && write_address[8:0] == lastAddr)
            lastData <= {writeEnable[1] ? write_data[17:9] : lastData[17:9],
                writeEnable[0] ? write_data[8:0] : lastData[8:0]};
    sequence quietRead;
        readSelect && !write_port_select;
    endsequence
    // contents start unknown: quiet until the memory has been filled
    default clocking dc @(posedge readClock); endclocking
    default disable iff (ageCount < 10'h2C0);
    AST_HOLD_IDLE: assert property (!readSelect |=> $stable(readData))
        else $error("read data moved without select");
    AST_HOLD_RUN: assert property (readSelect ##1 !readSelect [*3]
        |=> readData == $past(readData, 3)) else $error("read data drifted");
    AST_ONE_EDGE: assert property ($changed(readData) |-> $past(readSelect))
        else $error("read data changed late");
    AST_UPPER_ZERO: assert property (readData[35:18] == 18'h00000)
        else $error("unused read bits set");
    AST_PORT_ONE: assert property (first_port_read_data == 18'h00000)
        else $error("port one data outside true mode");
    AST_PORT_TWO: assert property (second_port_read_data == 18'h00000)
        else $error("port two data outside true mode");
    AST_READ_BACK: assert property (lastValid && readSelect
        && read_address[8:0] == lastAddr |=> readData[17:0] == $past(lastData))
        else $error("read back differs");
    AST_REPEAT: assert property (quietRead ##1 (quietRead ##0 $stable(read_address))
        |=> $stable(readData)) else $error("repeated read differs");
    cover property (write_port_select && writeEnable == 2'h1);
    cover property (quietRead ##1 quietRead);
    cover property (write_port_select && readSelect);
endmodule // dpram_block_assertions
bind dpram_block dpram_block_assertions chk (.writeClock(writeClock),
    .write_port_select(write_port_select), .writeEnable(writeEnable),
    .write_address(write_address), .write_data(write_data), .readClock(readClock),
    .readSelect(readSelect), .read_address(read_address), .readData(readData),
    .first_port_read_data(first_port_read_data), .second_port_read_data(second_port_read_data));
`default_nettype wire

// [test/dpram_fabric.sv]
// dpram_fabric.sv: fabric user logic on the simple write and read ports
// assumes: the bench calls issue once a clock, native shape only
`timescale 1ns/100ps
`default_nettype none
module dpram_fabric (
    input wire logic clock, // fabric clock
    output logic write_port_select = 1'b0, // write select
    output logic [1:0] writeEnable = 2'h0, // half enables
    output logic [10:0] write_address = 11'h000, // write address, shared lines
    output logic [35:0] write_data = 36'h000000000, // write word
    output logic readSelect = 1'b0, // read select
    output logic [10:0] read_address = 11'h000 // read address
);
    // ****
    // one request per rising edge
    // ****
    task issue(input logic ws, input logic [1:0] we, input logic [10:0] wa,
        input logic [35:0] wd, input logic rs, input logic [10:0] ra, output logic [10:0] raUsed);
        @(posedge clock);
        // no collision guard in the memory, so steer the read off the written word
        raUsed = (ws && we != 2'h0 && rs && ra[8:0] == wa[8:0]) ? ra ^ 11'h001 : ra;
        // only one write path is driven, so no double write to one word
        write_port_select <= ws;
        writeEnable <= we;
        write_address <= wa;
        write_data <= wd;
        readSelect <= rs;
        read_address <= raUsed;
    endtask
endmodule // dpram_fabric
`default_nettype wire

// [test/test_dual_port_ram_block.sv]
// test_dual_port_ram_block.sv: self-checking bench for the memory block
// assumes: 512x18 simple shape, both port clocks from one 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "dpram_regs.vh"
module test_dual_port_ram_block;
    logic clock = 1'b0;
    logic [17:0] p1Data = 18'h00000, p2Data = 18'h00000, expData;
    logic [9:0] p1Addr = 10'h000, p2Addr = 10'h000;
    logic p1Wen = 1'b0, p2Wen = 1'b0, p1Sel = 1'b0, p2Sel = 1'b0, expValid = 1'b0;
    logic [17:0] model [0:511];
    logic [31:0] r, w, seedDummy;
    int badCount = 0, checksDone = 0, i;
    wire wSel, rSel;
    wire [1:0] wEn;
    wire [10:0] wAddr, rAddr;
    wire [35:0] wData, readData;
    wire [17:0] p1Read, p2Read;
    dpram_fabric fab (.clock(clock), .write_port_select(wSel), .writeEnable(wEn),
        .write_address(wAddr), .write_data(wData), .readSelect(rSel), .read_address(rAddr));
    dpram_block #(.MODE(`DPRAM_MODE_SINGLE), .DEPTH(512), .PIPE(0)) DUT (.writeClock(clock),
        .write_port_select(wSel), .writeEnable(wEn), .write_address(wAddr),
        .write_data(wData), .readClock(clock), .readSelect(rSel), .read_address(rAddr),
        .readData(readData), .first_port_write_data(p1Data), .first_port_address(p1Addr),
        .first_port_write_enable(p1Wen), .first_port_select(p1Sel),
        .first_port_read_data(p1Read), .second_port_write_data(p2Data),
        .second_port_address(p2Addr), .second_port_write_enable(p2Wen),
        .second_port_select(p2Sel), .second_port_read_data(p2Read));
    // ****
    // checking and stepping
    // ****
    task automatic check(input logic [35:0] seen, input logic [35:0] expected);
        checksDone++;
        if (seen !== expected)
        begin
            badCount++;
            $display("mismatch %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task reportAndStop;
        if (badCount == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a result shows one edge after its request, so each step checks the step before
    task automatic cycle(input logic ws, input logic [1:0] we, input logic [10:0] wa,
        input logic [35:0] wd, input logic rs, input logic [10:0] ra);
        logic [10:0] raUsed;
        logic [17:0] nextExp;
        logic [31:0] t;
        fab.issue(ws, we, wa, wd, rs, ra, raUsed);
        t = $urandom;
        {p1Sel, p1Wen, p1Addr, p1Data} <= t[29:0];
        {p2Sel, p2Wen, p2Addr, p2Data} <= {t[31:30], t[27:0]};
        nextExp = rs ? model[raUsed[8:0]] : expData;
        if (ws && we[0])
            model[wa[8:0]][8:0] = wd[8:0];
        if (ws && we[1])
            model[wa[8:0]][17:9] = wd[17:9];
        @(negedge clock);
        if (expValid)
        begin
            check(readData, {18'h00000, expData});
            check({p1Read, p2Read}, 36'h000000000);
        end
        expData = nextExp;
        expValid = expValid | rs;
    endtask
    initial
        forever
            #25 clock = ~clock;
    initial
    begin
        #(50 * 4000);
        badCount++;
        reportAndStop;
    end
    initial
    begin
        seedDummy = $urandom(32'h9A8C47E8);
        repeat (5) @(posedge clock);
        for (i = 0; i < 512; i++)
        begin
            r = $urandom;
            cycle(1'b1, 2'h3, {r[31:30], i[8:0]}, {r[17:0], r[31:14]}, 1'b0, 11'h000);
        end
        for (i = 0; i < 512; i++)
            cycle(1'b0, 2'h0, 11'h000, 36'h000000000, 1'b1, {2'h3, i[8:0]});
        // a few words only, so half writes and reads keep meeting
        repeat (2000)
        begin
            r = $urandom;
            w = $urandom;
            cycle(r[0], r[2:1], {r[13:12], 5'h00, r[6:3]}, {w, r[31:28]}, r[14],
                {r[25:24], 5'h00, r[18:15]});
        end
        cycle(1'b0, 2'h0, 11'h000, 36'h000000000, 1'b0, 11'h000);
        reportAndStop;
    end
endmodule // test_dual_port_ram_block
`default_nettype wire
